// >>> common/cbt_pkg.sv
// constants and types shared by the bit timing and fault confinement block
package cbt_pkg;

    // ==========
    // serial command opcodes
    localparam logic [7:0] OP_WR_PRESCALER = 8'h18;
    localparam logic [7:0] OP_WR_SEGMENT = 8'h1A;
    localparam logic [7:0] OP_WR_TX_COUNT = 8'h26;
    localparam logic [7:0] OP_WR_RX_COUNT = 8'h24;
    localparam logic [7:0] OP_RD_PRESCALER = 8'hD6;
    localparam logic [7:0] OP_RD_SEGMENT = 8'hD8;
    localparam logic [7:0] OP_RD_TX_COUNT = 8'hEC;
    localparam logic [7:0] OP_RD_RX_COUNT = 8'hEA;
    localparam logic [7:0] OP_RD_FAULT = 8'hDC;

    // ==========
    // reset values and field positions
    localparam logic [7:0] PRESCALER_RESET = 8'h00;
    localparam logic [7:0] SEGMENT_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam int SJW_MSB = 7;
    localparam int SJW_LSB = 6;
    localparam int BRP_MSB = 5;
    localparam int BRP_LSB = 0;
    localparam int MAJORITY_VOTE_SELECT_BIT = 7;
    localparam int TS2_MSB = 6;
    localparam int TS2_LSB = 4;
    localparam int TS1_MSB = 3;
    localparam int TS1_LSB = 0;
    localparam int FLT_DETACH_BIT = 7;
    localparam int FLT_TXP_BIT = 6;
    localparam int FLT_RXP_BIT = 5;

    // ==========
    // fault confinement thresholds and steps
    localparam logic [7:0] WARN_LO = 8'h60;
    localparam logic [7:0] WARN_HI = 8'h7F;
    localparam logic [7:0] PASSIVE_LO = 8'h80;
    localparam logic [8:0] COUNT_MAX = 9'h0FF;
    localparam logic [7:0] TX_ERR_STEP = 8'h08;
    localparam logic [7:0] RX_ERR_STEP = 8'h01;
    localparam logic [7:0] RX_PRIMARY_STEP = 8'h08;
    localparam logic [7:0] RX_OK_RELOAD = 8'h77;
    localparam logic [3:0] RUN_LAST = 4'hA;
    localparam logic [7:0] GROUP_LAST = 8'h7F;

    typedef enum logic [1:0] {NODE_ACTIVE, NODE_PASSIVE, NODE_DETACHED} cbt_node_state_t;

endpackage

// >>> hdl/cbt_core.sv
// bit timing, sampling and fault confinement counters with serial register access
`timescale 1ns/100ps
module cbt_core import cbt_pkg::*; (
    input wire logic core_clk, // core clock, 100 MHz
    input wire logic resetn, // async reset, active low
    input wire logic spi_sck, // serial clock pin
    input wire logic spi_cs_n, // serial chip select pin, active low
    input wire logic spi_mosi, // serial data in pin
    output logic spi_miso, // serial data out pin
    output logic spi_miso_oe, // serial data out enable
    input wire logic can_rx, // bus receive pin, 1 = recessive
    input wire logic init_mode_active, // mode field top bit set
    input wire logic auto_rejoin_enable, // automatic bus-off recovery
    input wire logic warning_irq_enable, // warning interrupt enable
    input wire logic passive_irq_enable, // passive interrupt enable
    input wire logic detach_irq_enable, // detach interrupt enable
    input wire logic tx_err_evt, // pulse, transmit error seen
    input wire logic rx_err_evt, // pulse, receive error seen
    input wire logic rx_err_primary, // with rx_err_evt, primary error
    input wire logic tx_ok_evt, // pulse, frame sent
    input wire logic rx_ok_evt, // pulse, frame received
    output logic bit_sample_valid, // pulse, bit sampled
    output logic bit_sample_value, // sampled bit value
    output logic [7:0] tx_fault_count, // live transmit count
    output logic [7:0] rx_fault_count, // live receive count
    output logic warning_level_flag, // either count 96..127
    output logic passive_level_flag, // either side passive
    output logic tx_passive_flag, // transmit passive
    output logic rx_passive_flag, // receive passive
    output logic bus_detached_flag, // node is bus-off
    output cbt_node_state_t node_state, // confinement state
    output logic irq_request // enabled flag request
);

    // ==========
    // functions
    function automatic logic [8:0] count_add(input logic [7:0] v, input logic [7:0] step);
        return {1'b0, v} + {1'b0, step};
    endfunction

    function automatic logic [7:0] count_dec(input logic [7:0] v);
        return (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    function automatic logic in_band(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // ==========
    // pin synchronisers and serial slave
    logic [3:0] pins_s;
    logic [7:0] op_byte;
    logic [7:0] data_byte;
    logic data_done;
    logic [7:0] rd_byte;

    cbt_sync #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in({~can_rx, spi_mosi, ~spi_cs_n, spi_sck}), // idle-high pins inverted, reset reads idle
        .sync_out(pins_s)
    );

    wire logic can_rx_s = ~pins_s[3];

    cbt_spi_slave u_spi (
        .core_clk(core_clk),
        .resetn(resetn),
        .sck_s(pins_s[0]),
        .cs_n_s(~pins_s[1]),
        .mosi_s(pins_s[2]),
        .rd_byte(rd_byte),
        .op_byte(op_byte),
        .data_byte(data_byte),
        .data_done(data_done),
        .miso(spi_miso),
        .miso_oe(spi_miso_oe)
    );

    // ==========
    // registers and command decode
    logic [7:0] prescaler_jump_reg;
    logic [7:0] segment_sampling_reg;
    logic [7:0] tec_reg;
    logic [7:0] rec_reg;
    logic bus_off_reg;

    wire logic wr_prescaler = data_done && op_byte == OP_WR_PRESCALER && init_mode_active;
    wire logic wr_segment = data_done && op_byte == OP_WR_SEGMENT && init_mode_active;
    wire logic wr_tx_count = data_done && op_byte == OP_WR_TX_COUNT;
    wire logic wr_rx_count = data_done && op_byte == OP_WR_RX_COUNT;
    wire logic [7:0] fault_byte = {bus_off_reg, tx_passive_flag, rx_passive_flag, 5'h00};

    assign rd_byte = (op_byte == OP_RD_PRESCALER) ? prescaler_jump_reg :
                     (op_byte == OP_RD_SEGMENT) ? segment_sampling_reg :
                     (op_byte == OP_RD_TX_COUNT) ? tec_reg :
                     (op_byte == OP_RD_RX_COUNT) ? rec_reg :
                     (op_byte == OP_RD_FAULT) ? fault_byte : 8'h00;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prescaler_jump_reg <= PRESCALER_RESET;
            segment_sampling_reg <= SEGMENT_RESET;
        end else begin
            if (wr_prescaler)
                prescaler_jump_reg <= data_byte;
            if (wr_segment)
                segment_sampling_reg <= data_byte;
        end
    end

    // ==========
    // bit timing fields
    wire logic [1:0] resync_jump_width = prescaler_jump_reg[SJW_MSB:SJW_LSB];
    wire logic [5:0] quantum_prescaler = prescaler_jump_reg[BRP_MSB:BRP_LSB];
    wire logic majority_vote_select = segment_sampling_reg[MAJORITY_VOTE_SELECT_BIT];
    wire logic [2:0] phase_two_span = segment_sampling_reg[TS2_MSB:TS2_LSB];
    wire logic [3:0] phase_one_span = segment_sampling_reg[TS1_MSB:TS1_LSB];

    wire logic [2:0] sjw_tq = {1'b0, resync_jump_width} + 3'h1;
    wire logic [4:0] ts1_tq = {1'b0, phase_one_span} + 5'h01;
    wire logic [3:0] ts2_tq = {1'b0, phase_two_span} + 4'h1;

    // ==========
    // quantum prescaler and bit position
    logic [5:0] tq_cnt_reg;
    logic [5:0] q_reg;
    logic [2:0] ext_reg;
    logic [2:0] short_reg;
    logic resync_done_reg;
    logic [1:0] hist_reg;
    logic rx_prev_reg;
    logic smp_valid_reg;
    logic smp_value_reg;
    logic bus_idle_reg;

    wire logic tq_tick = (tq_cnt_reg == quantum_prescaler);
    wire logic [5:0] seg1_end = {1'b0, ts1_tq} + {3'h0, ext_reg};
    wire logic [5:0] bit_end = seg1_end + {2'h0, ts2_tq} - {3'h0, short_reg};
    wire logic [5:0] remaining = bit_end - q_reg + 6'h01;
    wire logic [5:0] sjw6 = {3'h0, sjw_tq};
    wire logic edge_fall = rx_prev_reg & ~can_rx_s;
    wire logic in_phase1 = (q_reg <= seg1_end);
    wire logic vote = (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & can_rx_s) | (hist_reg[0] & can_rx_s);

    logic [5:0] tq_cnt_next;
    logic [5:0] q_next;
    logic [2:0] ext_next;
    logic [2:0] short_next;
    logic resync_done_next;
    logic [1:0] hist_next;
    logic smp_valid_next;
    logic smp_value_next;

    always_comb begin
        logic restart;
        restart = 1'b0;
        tq_cnt_next = tq_tick ? 6'h00 : tq_cnt_reg + 6'h01;
        q_next = q_reg;
        ext_next = ext_reg;
        short_next = short_reg;
        resync_done_next = resync_done_reg;
        hist_next = hist_reg;
        smp_valid_next = 1'b0;
        smp_value_next = smp_value_reg;
        if (init_mode_active) begin
            tq_cnt_next = 6'h00;
            q_next = 6'h00;
            ext_next = 3'h0;
            short_next = 3'h0;
            resync_done_next = 1'b0;
        end else if (edge_fall && bus_idle_reg) begin
            // hard synchronisation on a frame start
            tq_cnt_next = 6'h00;
            q_next = 6'h00;
            ext_next = 3'h0;
            short_next = 3'h0;
            resync_done_next = 1'b1;
        end else begin
            if (edge_fall && !resync_done_reg && q_reg != 6'h00) begin
                resync_done_next = 1'b1;
                if (in_phase1) begin
                    ext_next = (q_reg > sjw6) ? sjw_tq : q_reg[2:0];
                end else if (remaining <= sjw6) begin
                    restart = 1'b1;
                    tq_cnt_next = 6'h00;
                    q_next = 6'h00;
                    ext_next = 3'h0;
                    short_next = 3'h0;
                end else begin
                    short_next = sjw_tq;
                end
            end
            if (tq_tick && !restart) begin
                hist_next = {hist_reg[0], can_rx_s};
                if (q_reg == seg1_end) begin
                    smp_valid_next = 1'b1;
                    smp_value_next = majority_vote_select ? vote : can_rx_s;
                end
                if (q_reg >= bit_end) begin
                    q_next = 6'h00;
                    ext_next = 3'h0;
                    short_next = 3'h0;
                    resync_done_next = 1'b0;
                end else begin
                    q_next = q_reg + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tq_cnt_reg <= 6'h00;
            q_reg <= 6'h00;
            ext_reg <= 3'h0;
            short_reg <= 3'h0;
            resync_done_reg <= 1'b0;
            hist_reg <= 2'h3;
            rx_prev_reg <= 1'b1;
            smp_valid_reg <= 1'b0;
            smp_value_reg <= 1'b1;
        end else begin
            tq_cnt_reg <= tq_cnt_next;
            q_reg <= q_next;
            ext_reg <= ext_next;
            short_reg <= short_next;
            resync_done_reg <= resync_done_next;
            hist_reg <= hist_next;
            rx_prev_reg <= can_rx_s;
            smp_valid_reg <= smp_valid_next;
            smp_value_reg <= smp_value_next;
        end
    end

    // ==========
    // recessive run counting for idle and bus-off recovery
    logic [3:0] run_reg;
    logic [7:0] group_reg;

    wire logic run_complete = smp_valid_reg && smp_value_reg && run_reg == RUN_LAST;
    wire logic recovery_seen = run_complete && bus_off_reg && group_reg == GROUP_LAST;
    wire logic recover_now = recovery_seen && auto_rejoin_enable;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_reg <= 4'h0;
            group_reg <= 8'h00;
            bus_idle_reg <= 1'b0;
        end else if (smp_valid_reg && !smp_value_reg) begin
            run_reg <= 4'h0;
            group_reg <= 8'h00;
            bus_idle_reg <= 1'b0;
        end else if (run_complete) begin
            run_reg <= 4'h0;
            group_reg <= (bus_off_reg && !recovery_seen) ? group_reg + 8'h01 : 8'h00;
            bus_idle_reg <= 1'b1;
        end else if (smp_valid_reg) begin
            run_reg <= run_reg + 4'h1;
        end
    end

    // ==========
    // fault counters
    wire logic [8:0] tx_sum = count_add(tec_reg, TX_ERR_STEP);
    wire logic [8:0] rx_sum = count_add(rec_reg, rx_err_primary ? RX_PRIMARY_STEP : RX_ERR_STEP);

    logic [7:0] tec_next;
    logic [7:0] rec_next;
    logic bus_off_next;

    always_comb begin
        tec_next = tec_reg;
        bus_off_next = bus_off_reg;
        if (wr_tx_count) begin
            tec_next = data_byte;
            if (!auto_rejoin_enable)
                bus_off_next = 1'b0;
        end else if (bus_off_reg) begin
            if (recover_now) begin
                tec_next = COUNT_RESET;
                bus_off_next = 1'b0;
            end
        end else if (tx_err_evt) begin
            if (tx_sum > COUNT_MAX) begin
                tec_next = COUNT_MAX[7:0];
                bus_off_next = 1'b1;
            end else begin
                tec_next = tx_sum[7:0];
            end
        end else if (tx_ok_evt) begin
            tec_next = count_dec(tec_reg);
        end
    end

    always_comb begin
        rec_next = rec_reg;
        if (wr_rx_count) begin
            rec_next = data_byte;
        end else if (recover_now) begin
            rec_next = COUNT_RESET;
        end else if (!bus_off_reg && rx_err_evt) begin
            rec_next = (rx_sum > COUNT_MAX) ? COUNT_MAX[7:0] : rx_sum[7:0];
        end else if (!bus_off_reg && rx_ok_evt) begin
            rec_next = (rec_reg >= PASSIVE_LO) ? RX_OK_RELOAD : count_dec(rec_reg);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tec_reg <= COUNT_RESET;
            rec_reg <= COUNT_RESET;
            bus_off_reg <= 1'b0;
        end else begin
            tec_reg <= tec_next;
            rec_reg <= rec_next;
            bus_off_reg <= bus_off_next;
        end
    end

    // ==========
    // status flags and state
    wire logic warn_now = in_band(tec_reg, WARN_LO, WARN_HI) || in_band(rec_reg, WARN_LO, WARN_HI);
    wire logic txp_now = (tec_reg >= PASSIVE_LO) && !bus_off_reg;
    wire logic rxp_now = (rec_reg >= PASSIVE_LO);
    wire logic pass_now = txp_now || rxp_now;
    wire logic irq_now = (warn_now && warning_irq_enable) || (pass_now && passive_irq_enable) ||
                         (bus_off_reg && detach_irq_enable);

    logic warn_reg;
    logic pass_reg;
    logic txp_reg;
    logic rxp_reg;
    logic detach_reg;
    logic irq_reg;
    cbt_node_state_t state_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            warn_reg <= 1'b0;
            pass_reg <= 1'b0;
            txp_reg <= 1'b0;
            rxp_reg <= 1'b0;
            detach_reg <= 1'b0;
            irq_reg <= 1'b0;
            state_reg <= NODE_ACTIVE;
        end else begin
            warn_reg <= warn_now;
            pass_reg <= pass_now;
            txp_reg <= txp_now;
            rxp_reg <= rxp_now;
            detach_reg <= bus_off_reg;
            irq_reg <= irq_now;
            state_reg <= bus_off_reg ? NODE_DETACHED : (pass_now ? NODE_PASSIVE : NODE_ACTIVE);
        end
    end

    assign bit_sample_valid = smp_valid_reg;
    assign bit_sample_value = smp_value_reg;
    assign tx_fault_count = tec_reg;
    assign rx_fault_count = rec_reg;
    assign warning_level_flag = warn_reg;
    assign passive_level_flag = pass_reg;
    assign tx_passive_flag = txp_reg;
    assign rx_passive_flag = rxp_reg;
    assign bus_detached_flag = detach_reg;
    assign node_state = state_reg;
    assign irq_request = irq_reg;
endmodule

// >>> hdl/cbt_spi_slave.sv
// serial command slave, clock idle low, data taken on the rising edge
`timescale 1ns/100ps
module cbt_spi_slave import cbt_pkg::*; (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic sck_s, // synchronised serial clock
    input wire logic cs_n_s, // synchronised chip select, active low
    input wire logic mosi_s, // synchronised serial data in
    input wire logic [7:0] rd_byte, // read data for the held opcode
    output logic [7:0] op_byte, // opcode of current frame
    output logic [7:0] data_byte, // latest data byte
    output logic data_done, // pulse, data byte complete
    output logic miso, // serial data out
    output logic miso_oe // data out enable
);
    logic sck_prev_reg;
    logic first_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] op_reg;
    logic [7:0] data_reg;
    logic done_reg;
    logic oe_reg;

    wire logic sck_rise = sck_s & ~sck_prev_reg;
    wire logic sck_fall = ~sck_s & sck_prev_reg;
    wire logic byte_end = sck_rise && (bit_cnt_reg == 3'h7);
    wire logic [7:0] rx_full = {rx_sh_reg, mosi_s};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev_reg <= 1'b0;
            first_reg <= 1'b1;
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
            tx_sh_reg <= 8'h00;
            op_reg <= 8'h00;
            data_reg <= 8'h00;
            done_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
            done_reg <= byte_end && !first_reg && !cs_n_s;
            if (cs_n_s) begin
                first_reg <= 1'b1;
                bit_cnt_reg <= 3'h0;
                oe_reg <= 1'b0;
                tx_sh_reg <= 8'h00;
            end else begin
                if (sck_rise) begin
                    rx_sh_reg <= rx_full[6:0];
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                end
                if (byte_end && first_reg) begin
                    op_reg <= rx_full;
                    first_reg <= 1'b0;
                end
                if (byte_end && !first_reg)
                    data_reg <= rx_full;
                // reload at each byte boundary after the opcode
                if (sck_fall && !first_reg && bit_cnt_reg == 3'h0) begin
                    tx_sh_reg <= rd_byte;
                    oe_reg <= 1'b1;
                end else if (sck_fall) begin
                    tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                end
            end
        end
    end

    assign op_byte = op_reg;
    assign data_byte = data_reg;
    assign data_done = done_reg;
    assign miso = tx_sh_reg[7];
    assign miso_oe = oe_reg;
endmodule

// >>> hdl/cbt_sync.sv
// two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/100ps
module cbt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pins
    output logic [WIDTH-1:0] sync_out // synchronised pins
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// >>> verif/cbt_can_node.sv
// far bus node: idle recessive, dominant bursts on request
`timescale 1ns/100ps
module cbt_can_node (
    input wire logic core_clk, // clock
    input wire logic start, // begin dominant burst
    input wire logic [15:0] burst_len, // burst length in cycles
    output logic bus_level // 1 = recessive
);
    int left = 0;
    always @(posedge core_clk) begin
        if (start) left <= burst_len;
        else if (left > 0) left <= left - 1;
    end
    assign bus_level = (left == 0);
endmodule

// >>> verif/cbt_core_monitor.sv
// assertion checker for the bit timing and fault confinement block
`timescale 1ns/100ps
module cbt_core_monitor import cbt_pkg::*; (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic auto_rejoin_enable, // rejoin
    input wire logic warning_irq_enable, // warn enable
    input wire logic tx_err_evt, // tx error
    input wire logic rx_err_evt, // rx error
    input wire logic rx_err_primary, // primary
    input wire logic tx_ok_evt, // tx ok
    input wire logic rx_ok_evt, // rx ok
    input wire logic [7:0] tx_fault_count, // tx count
    input wire logic [7:0] rx_fault_count, // rx count
    input wire logic warning_level_flag, // warn
    input wire logic rx_passive_flag, // rx passive
    input wire logic bus_detached_flag, // bus-off
    input wire cbt_node_state_t node_state, // state
    input wire logic irq_request // irq
);
    wire warn_c = (tx_fault_count inside {[WARN_LO:WARN_HI]}) || (rx_fault_count inside {[WARN_LO:WARN_HI]});
    wire live = node_state != NODE_DETACHED;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========
    // counters and flags
    a_warn_flag_lag: assert property (warning_level_flag == $past(warn_c))
        else $error("warn flag lag");
    a_rx_passive_lag: assert property (rx_passive_flag == $past(rx_fault_count[7]))
        else $error("rx passive lag");
    a_tx_err_step: assert property (tx_err_evt && live && tx_fault_count < 8'hF8 |=>
        tx_fault_count == $past(tx_fault_count) + 8'h08) else $error("tx step");
    a_rx_err_step: assert property (rx_err_evt && live && rx_fault_count < 8'hF8 |=>
        rx_fault_count == $past(rx_fault_count) + ($past(rx_err_primary) ? 8'h08 : 8'h01))
        else $error("rx step");
    a_tx_ok_dec: assert property (tx_ok_evt && !tx_err_evt && live && tx_fault_count != 8'h00 |=>
        tx_fault_count == $past(tx_fault_count) - 8'h01) else $error("tx dec");
    a_rx_ok_reload: assert property (rx_ok_evt && !rx_err_evt && live && rx_fault_count[7] |=>
        rx_fault_count == RX_OK_RELOAD) else $error("rx reload wrong");
    a_bus_detached_flag_entry: assert property (tx_err_evt && live && tx_fault_count >= 8'hF8 |=>
        tx_fault_count == 8'hFF ##1 bus_detached_flag && node_state == NODE_DETACHED) else $error("no bus-off");
    a_rx_frozen_off: assert property (!live && !auto_rejoin_enable && rx_err_evt |=> $stable(rx_fault_count))
        else $error("rx moved");
    a_warn_irq_req: assert property ((warning_level_flag && warning_irq_enable) [*2] |-> irq_request)
        else $error("warn irq");
    cover property (node_state == NODE_DETACHED ##1 node_state == NODE_ACTIVE);
    cover property (rx_ok_evt && rx_fault_count[7]);
    cover property (tx_err_evt && tx_fault_count >= 8'hF8);
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the bit timing and fault confinement block
`timescale 1ns/100ps
module tb_top import cbt_pkg::*; ();
    logic core_clk = 0, resetn = 0, sck = 0, cs_n = 1, mosi = 0, init_m = 0, rejoin = 0, we = 0, pe = 0, de = 0;
    logic te = 0, re = 0, rp = 0, to = 0, ro = 0, go = 0;
    wire miso, oe, can_rx, sv, sval, wf, pf, tp, rxp, det, irq;
    wire [7:0] tx_fault_counter, rx_fault_counter;
    cbt_node_state_t st;
    int errors = 0, samples_checked = 0, tx_m = 0, rx_m = 0, det_m = 0, c;
    logic [7:0] q, a, b;
    logic [7:0] ops [6] = '{OP_RD_PRESCALER, OP_RD_SEGMENT, OP_RD_TX_COUNT, OP_RD_RX_COUNT, OP_RD_FAULT, 8'hC3};
    cbt_core dut_u (.core_clk(core_clk), .resetn(resetn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(oe), .can_rx(can_rx), .init_mode_active(init_m), .auto_rejoin_enable(rejoin),
        .warning_irq_enable(we), .passive_irq_enable(pe), .detach_irq_enable(de), .tx_err_evt(te), .rx_err_evt(re),
        .rx_err_primary(rp), .tx_ok_evt(to), .rx_ok_evt(ro), .bit_sample_valid(sv), .bit_sample_value(sval),
        .tx_fault_count(tx_fault_counter), .rx_fault_count(rx_fault_counter), .warning_level_flag(wf), .passive_level_flag(pf),
        .tx_passive_flag(tp), .rx_passive_flag(rxp), .bus_detached_flag(det), .node_state(st), .irq_request(irq));
    cbt_can_node node_u (.core_clk(core_clk), .start(go), .burst_len(16'h0018), .bus_level(can_rx));
    initial forever #5 core_clk = ~core_clk;
    task tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task spi(input logic [7:0] op, input logic [7:0] d);
        cs_n = 0;
        tk(5);
        for (int i = 0; i < 16; i++) begin
            mosi = (i < 8) ? op[7 - i] : d[15 - i];
            tk(5);
            sck = 1;
            tk(5);
            if (i > 7) q = {q[6:0], miso};
            sck = 0;
        end
        tk(10);
        cs_n = 1;
        tk(10);
    endtask
    task cmp();
        logic w, p;
        w = (tx_m inside {[96:127]}) || (rx_m inside {[96:127]});
        p = tx_m > 127 || rx_m > 127;
        chk("tx_fault_count", tx_fault_counter, 8'(tx_m));
        chk("rx_fault_count", rx_fault_counter, 8'(rx_m));
        chk("warning_level_flag", 8'(wf), 8'(w));
        chk("rx_passive_flag", 8'(rxp), 8'(rx_m > 127));
        chk("bus_detached_flag", 8'(det), 8'(det_m));
        if (det_m == 0) chk("tx_passive_flag", 8'(tp), 8'(tx_m > 127));
        if (det_m == 0) chk("passive_level_flag", 8'(pf), 8'(p));
        if (det_m == 0) chk("irq_request", 8'(irq), 8'((we && w) || (pe && p)));
    endtask
    task ev(input int k);
        {te, re, rp, to, ro} = {k < 2, k == 2 || k == 3, k == 2, k == 4, k > 4};
        tk(1);
        {te, re, rp, to, ro} = 5'h00;
        if (det_m == 0) begin
            if (k < 2) det_m = (tx_m > 247);
            if (k < 2) tx_m = det_m ? 255 : tx_m + 8;
            if (k == 2 || k == 3) rx_m = rx_m + (k == 2 ? 8 : 1);
            if (rx_m > 255) rx_m = 255;
            if (k == 4 && tx_m > 0) tx_m--;
            if (k > 4) rx_m = rx_m > 127 ? 119 : (rx_m > 0 ? rx_m - 1 : 0);
        end
        tk(4);
        cmp();
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        $display("[ERR] watchdog exp done seen hang");
        finish_test();
    end
    initial begin
        void'($urandom(22218));
        tk(10);
        resetn = 1;
        tk(4);
        foreach (ops[i]) begin
            spi(ops[i], 8'h00);
            chk("reset value", q, 8'h00);
        end
        a = 8'($urandom) | 8'h01;
        spi(OP_WR_PRESCALER, a);
        spi(OP_RD_PRESCALER, 8'h00);
        chk("locked prescaler", q, 8'h00);
        $display("regs done");
        for (int n = 0; n < 4; n++) begin
            a = 8'($urandom % 4);
            b = {1'($urandom), 3'(1 + $urandom % 7), 4'(7 + $urandom % 9)};
            init_m = 1;
            spi(OP_WR_PRESCALER, a);
            spi(OP_WR_SEGMENT, b);
            spi(OP_RD_SEGMENT, 8'h00);
            chk("segment", q, b);
            init_m = 0;
            c = 0;
            while (sv !== 1'b1 && c < 3000) begin tk(1); c++; end
            tk(1);
            c = 1;
            while (sv !== 1'b1 && c < 3000) begin tk(1); c++; end
            chk("bit period", 8'(c), 8'((a + 1) * (3 + b[3:0] + b[6:4])));
            chk("idle sample", 8'(sval), 8'h01);
        end
        init_m = 1;
        spi(OP_WR_PRESCALER, 8'h00);
        spi(OP_WR_SEGMENT, 8'h14);
        init_m = 0;
        $display("timing done");
        tx_m = $urandom % 200;
        rx_m = $urandom % 200;
        spi(OP_WR_TX_COUNT, 8'(tx_m));
        spi(OP_WR_RX_COUNT, 8'(rx_m));
        spi(OP_RD_TX_COUNT, 8'h00);
        chk("tx read", q, 8'(tx_m));
        spi(OP_RD_RX_COUNT, 8'h00);
        chk("rx read", q, 8'(rx_m));
        for (int n = 0; n < 80; n++) begin
            {we, pe, de} = 3'($urandom);
            ev($urandom % 6);
        end
        $display("counters done");
        for (int n = 0; n < 2; n++) begin
            spi(OP_WR_TX_COUNT, 8'hF8);
            spi(OP_WR_RX_COUNT, 8'h00);
            rejoin = (n == 0);
            {tx_m, rx_m, det_m} = {32'd248, 64'd0};
            ev(0);
            ev(3);
            tk(5600);
            go = (n == 0);
            tk(1);
            go = 0;
            tk(11200);
            chk("still detached", 8'(det), 8'h01);
            chk("irq", 8'(irq), 8'(de));
            if (n == 1) spi(OP_WR_TX_COUNT, 8'h00);
            c = 0;
            while (st !== NODE_ACTIVE && c < 1000) begin tk(1); c++; end
            tk(3);
            {tx_m, rx_m, det_m} = 96'd0;
            cmp();
            chk("node_state", 8'(st), 8'(NODE_ACTIVE));
        end
        $display("recovery done");
        finish_test();
    end
endmodule
bind cbt_core cbt_core_monitor mon_u (.*);
